// ### logic/pmacs_pkg.sv
// pmacs_pkg: constants of the medium attachment management register set.
// assumes a 100 MHz core clock and a clause 45 frame on the mdio pins.
package pmacs_pkg;
  localparam logic [4:0] MMD_ADDR = 5'h01;
  localparam logic [15:0] OFS_CTRL1 = 16'h0000;
  localparam logic [15:0] OFS_STAT1 = 16'h0001;
  localparam logic [15:0] OFS_PKG1 = 16'h0005;
  localparam logic [15:0] OFS_PKG2 = 16'h0006;
  localparam logic [15:0] OFS_CTRL2 = 16'h0007;
  localparam int BIT_SRST = 15;
  localparam int BIT_PD = 11;
  localparam int BIT_LB = 0;
  localparam int BIT_LINK = 2;
  localparam int BIT_PDABLE = 1;
  localparam logic [15:0] PKG1_VAL = 16'h008b;
  localparam logic [15:0] PKG2_VAL = 16'hc000;
  localparam logic [6:0] TYPE_RST = 7'h3d;
  localparam logic [1:0] ST_C45 = 2'h0;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RDINC = 2'h2;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0d;
  localparam logic [5:0] TA_BIT = 6'h0e;
  localparam logic [5:0] FRAME_LAST = 6'h1f;
  localparam logic [2:0] STRAP_SETTLE = 3'h5;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RST_NS = 1000;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  typedef enum logic {ST_PREAMBLE, ST_FRAME} pmacs_state_t;
endpackage : pmacs_pkg

// ### logic/pmacs_regs.sv
// pmacs_regs: clause 45 mdio slave holding the attachment-layer registers.
// assumes mdc/mdio/strap are asynchronous pins; link and negotiation
// inputs and the symbol paths come from logic on i_clk.
`timescale 1ns/10ps
module pmacs_regs #(
  parameter logic [4:0] PORT_ADDR = 5'h00,
  parameter int SYM_W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  input wire logic i_power_down_strap_pin,
  input wire logic i_link_up,
  input wire logic i_an_enable,
  input wire logic i_forced_cfg,
  input wire logic [6:0] i_an_phy_type,
  input wire logic [SYM_W-1:0] i_tx_sym,
  input wire logic [SYM_W-1:0] i_line_sym,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  output logic o_soft_reset_active,
  output logic o_power_down,
  output logic o_local_loopback,
  output logic [6:0] o_phy_type,
  output logic [SYM_W-1:0] o_rx_sym
);
  localparam int RST_CYC = pmacs_pkg::SOFT_RST_CYC;
  localparam int CW = $clog2(RST_CYC + 1);
  localparam int RST_LO = RST_CYC - 1;

  // pin order: strap, mdio, mdc
  logic [2:0] s1, s2, s3, lvl, next_lvl, agree;
  pmacs_pkg::pmacs_state_t st, next_st;
  logic [5:0] ones, next_ones, idx, next_idx;
  logic [13:0] hdr, next_hdr;
  logic [15:0] shreg, next_sh, addr, next_addr, wdata, rdata;
  logic sel, next_sel, next_out, next_oe, next_busy;
  logic [1:0] op, next_op;
  logic [CW-1:0] cnt, next_cnt;
  logic [2:0] settle, next_settle;
  logic ll, next_ll, next_pd, next_lb, rise, d, rd_go, wr_go;
  logic [6:0] type_sel, next_type, next_phy;
  logic [SYM_W-1:0] next_rx;

  // sync flops carry no reset so they are settled when reset lifts
  always_ff @(posedge i_clk) begin
    s1 <= {i_power_down_strap_pin, i_mdio_in, i_mdc};
    s2 <= s1;
    s3 <= s2;
  end

  always_comb begin
    case (addr)
      pmacs_pkg::OFS_CTRL1: begin
        rdata = 16'h0000;
        rdata[pmacs_pkg::BIT_SRST] = o_soft_reset_active;
        rdata[pmacs_pkg::BIT_PD] = o_power_down;
        rdata[pmacs_pkg::BIT_LB] = o_local_loopback;
      end
      pmacs_pkg::OFS_STAT1: begin
        rdata = 16'h0000;
        rdata[pmacs_pkg::BIT_LINK] = ll;
        rdata[pmacs_pkg::BIT_PDABLE] = 1'b1;
      end
      pmacs_pkg::OFS_PKG1: rdata = pmacs_pkg::PKG1_VAL;
      pmacs_pkg::OFS_PKG2: rdata = pmacs_pkg::PKG2_VAL;
      pmacs_pkg::OFS_CTRL2: rdata = {9'h000, type_sel};
      default: rdata = 16'h0000;
    endcase
  end

  always_comb begin
    agree = ~(s2 ^ s3);
    next_lvl = (agree & s3) | (~agree & lvl);
    rise = next_lvl[0] & ~lvl[0];
    d = next_lvl[1];
    wdata = {shreg[14:0], d};
    next_st = st;
    next_ones = ones;
    next_idx = idx;
    next_hdr = hdr;
    next_sh = shreg;
    next_addr = addr;
    next_sel = sel;
    next_op = op;
    next_out = o_mdio_out;
    next_oe = o_mdio_oe;
    next_cnt = cnt;
    next_settle = settle;
    next_pd = o_power_down;
    next_lb = o_local_loopback;
    next_type = type_sel;
    rd_go = 1'b0;
    wr_go = 1'b0;
    // mdio decoding never looks at power-down, so access stays open
    if (rise) begin
      case (st)
        pmacs_pkg::ST_PREAMBLE: begin
          if (d && ones != pmacs_pkg::PRE_LEN) begin
            next_ones = ones + 6'h01;
          end else if (!d) begin
            if (ones == pmacs_pkg::PRE_LEN) begin
              next_st = pmacs_pkg::ST_FRAME;
              next_idx = 6'h01;
              next_hdr = 14'h0000;
            end
            next_ones = 6'h00;
          end
        end
        pmacs_pkg::ST_FRAME: begin
          next_idx = idx + 6'h01;
          if (idx <= pmacs_pkg::HDR_LAST) begin
            next_hdr = {hdr[12:0], d};
          end
          if (idx == pmacs_pkg::HDR_LAST) begin
            next_op = next_hdr[11:10];
            next_sel = next_hdr[13:12] == pmacs_pkg::ST_C45
                       && next_hdr[9:5] == PORT_ADDR
                       && next_hdr[4:0] == pmacs_pkg::MMD_ADDR;
          end
          if (idx == pmacs_pkg::TA_BIT) begin
            if (sel && op[1]) begin
              rd_go = 1'b1;
              next_oe = 1'b1;
              next_out = 1'b0;
              next_sh = rdata;
              if (op == pmacs_pkg::OP_RDINC) begin
                next_addr = addr + 16'h0001;
              end
            end
          end else if (idx > pmacs_pkg::TA_BIT) begin
            next_out = shreg[15];
            next_sh = wdata;
          end
          if (idx == pmacs_pkg::FRAME_LAST) begin
            next_st = pmacs_pkg::ST_PREAMBLE;
            next_oe = 1'b0;
            wr_go = sel && !op[1];
          end
        end
        default: next_st = pmacs_pkg::ST_PREAMBLE;
      endcase
    end
    // strap is sampled only once the sync chain has settled
    if (settle != pmacs_pkg::STRAP_SETTLE) begin
      next_settle = settle + 3'h1;
    end
    if (settle == pmacs_pkg::STRAP_SETTLE - 3'h1) begin
      next_pd = lvl[2];
    end
    if (cnt != '0) begin
      next_cnt = cnt - CW'(1);
    end
    if (wr_go && op == pmacs_pkg::OP_ADDR) begin
      next_addr = wdata;
    end
    // writes only land in the defined bits; the rest is dropped
    if (wr_go && op == pmacs_pkg::OP_WRITE) begin
      if (addr == pmacs_pkg::OFS_CTRL1) begin
        next_pd = wdata[pmacs_pkg::BIT_PD];
        next_lb = wdata[pmacs_pkg::BIT_LB];
        if (wdata[pmacs_pkg::BIT_SRST]) begin
          next_cnt = CW'(RST_CYC);
        end
      end
      if (addr == pmacs_pkg::OFS_CTRL2) begin
        next_type = wdata[6:0];
      end
    end
    // the end of a soft reset overrides a write landing in its last cycle
    if (cnt == CW'(1)) begin
      next_pd = lvl[2];
      next_lb = 1'b0;
      next_type = pmacs_pkg::TYPE_RST;
    end
    next_busy = next_cnt != '0;
    // a drop in the read cycle beats the re-arm
    next_ll = i_link_up
              && (ll || (rd_go && addr == pmacs_pkg::OFS_STAT1));
    next_phy = (!i_an_enable && i_forced_cfg) ? type_sel
               : i_an_phy_type;
    next_rx = o_local_loopback ? i_tx_sym : i_line_sym;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      lvl <= 3'h0;
      st <= pmacs_pkg::ST_PREAMBLE;
      ones <= 6'h00;
      idx <= 6'h00;
      hdr <= 14'h0000;
      shreg <= 16'h0000;
      addr <= 16'h0000;
      sel <= 1'b0;
      op <= 2'h0;
      o_mdio_out <= 1'b0;
      o_mdio_oe <= 1'b0;
      cnt <= '0;
      settle <= 3'h0;
      ll <= 1'b0;
      o_soft_reset_active <= 1'b0;
      o_power_down <= 1'b0;
      o_local_loopback <= 1'b0;
      type_sel <= pmacs_pkg::TYPE_RST;
      o_phy_type <= pmacs_pkg::TYPE_RST;
      o_rx_sym <= '0;
    end else begin
      lvl <= next_lvl;
      st <= next_st;
      ones <= next_ones;
      idx <= next_idx;
      hdr <= next_hdr;
      shreg <= next_sh;
      addr <= next_addr;
      sel <= next_sel;
      op <= next_op;
      o_mdio_out <= next_out;
      o_mdio_oe <= next_oe;
      cnt <= next_cnt;
      settle <= next_settle;
      ll <= next_ll;
      o_soft_reset_active <= next_busy;
      o_power_down <= next_pd;
      o_local_loopback <= next_lb;
      type_sel <= next_type;
      o_phy_type <= next_phy;
      o_rx_sym <= next_rx;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_srst_reinit;
    $fell(o_soft_reset_active) |-> !o_local_loopback
      && type_sel == pmacs_pkg::TYPE_RST;
  endproperty
  a_srst_reinit: assert property (p_srst_reinit)
    else $error("soft reset left loopback or type select");
  property p_srst_len;
    $rose(o_soft_reset_active) && !wr_go |->
      ##[RST_LO:RST_CYC] !o_soft_reset_active;
  endproperty
  a_srst_len: assert property (p_srst_len)
    else $error("soft reset did not self clear in time");
  property p_pd_write;
    wr_go && op == pmacs_pkg::OP_WRITE && addr == pmacs_pkg::OFS_CTRL1
      && cnt != CW'(1) |=> o_power_down == $past(wdata[11]);
  endproperty
  a_pd_write: assert property (p_pd_write)
    else $error("power-down bit not taken from write");
  property p_pd_access;
    o_power_down && rd_go |=> o_mdio_oe ##1 o_mdio_oe;
  endproperty
  a_pd_access: assert property (p_pd_access)
    else $error("read not answered during power-down");
  property p_strap;
    settle == pmacs_pkg::STRAP_SETTLE - 3'h1 |=>
      o_power_down == $past(lvl[2]);
  endproperty
  a_strap: assert property (p_strap)
    else $error("power-down not loaded from strap");
  property p_loop;
    o_local_loopback |=> o_rx_sym == $past(i_tx_sym);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback did not return transmit symbols");
  property p_link_ll;
    !i_link_up |=> !ll ##1 (!ll || $past(rd_go));
  endproperty
  a_link_ll: assert property (p_link_ll)
    else $error("link status did not latch low");
  property p_stat_word;
    rd_go && addr == pmacs_pkg::OFS_STAT1 |=>
      shreg[1] && shreg[2] == $past(ll) && shreg[15:3] == 13'h0000;
  endproperty
  a_stat_word: assert property (p_stat_word)
    else $error("status word wrong");
  property p_pkg;
    rd_go && addr == pmacs_pkg::OFS_PKG1 |=> shreg == 16'h008b;
  endproperty
  a_pkg: assert property (p_pkg)
    else $error("units present low wrong");
  property p_pkg2;
    rd_go && addr == pmacs_pkg::OFS_PKG2 |=> shreg == 16'hc000;
  endproperty
  a_pkg2: assert property (p_pkg2)
    else $error("units present high wrong");
  property p_type;
    !i_an_enable && i_forced_cfg |=> o_phy_type == $past(type_sel);
  endproperty
  a_type: assert property (p_type)
    else $error("forced type not applied");
  property p_an_type;
    i_an_enable |=> o_phy_type == $past(i_an_phy_type);
  endproperty
  a_an_type: assert property (p_an_type)
    else $error("negotiated type not applied");
endmodule : pmacs_regs

// ### verification/pmacs_station.sv
// pmacs_station: behavioural mdio management station for the bench.
// assumes the bench resolves the mdio wire with a pull-up to one.
`timescale 1ns/10ps
module pmacs_station #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input wire logic i_clk,
  input wire logic i_mdio_wire,
  output logic o_mdc,
  output logic o_mdio_drive,
  output logic o_mdio_oe
);
  int half = 5;
  logic smp;
  initial begin
    o_mdc = 1'b0;
    o_mdio_drive = 1'b1;
    o_mdio_oe = 1'b0;
  end
  // the wire is sampled as mdc rises, before that edge's updates land
  task automatic send_bit(input logic b, input logic drv);
    o_mdio_oe <= drv;
    o_mdio_drive <= b;
    repeat (half) @(posedge i_clk);
    o_mdc <= 1'b1;
    smp = i_mdio_wire;
    repeat (half) @(posedge i_clk);
    o_mdc <= 1'b0;
  endtask : send_bit
  task automatic frame(input logic [1:0] op, input logic [15:0] d,
                       output logic [15:0] q);
    logic [31:0] w;
    w = {pmacs_pkg::ST_C45, op, PORT_ADDR, pmacs_pkg::MMD_ADDR, 2'b10, d};
    q = 16'h0000;
    @(posedge i_clk);
    for (int i = 0; i < 32; i++) send_bit(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--) begin
      // a read hands the wire over from the turnaround on
      send_bit(w[i], !(op[1] && i < 18));
      if (i < 16) q[i] = smp;
    end
    o_mdio_oe <= 1'b0;
  endtask : frame
  task automatic rd(input logic [15:0] ofs, output logic [15:0] q);
    frame(pmacs_pkg::OP_ADDR, ofs, q);
    frame(2'h3, 16'h0000, q);
  endtask : rd
  task automatic wr(input logic [15:0] ofs, input logic [15:0] d);
    logic [15:0] q;
    frame(pmacs_pkg::OP_ADDR, ofs, q);
    frame(pmacs_pkg::OP_WRITE, d, q);
  endtask : wr
endmodule : pmacs_station

// ### verification/pmacs_regs_tb.sv
// pmacs_regs_tb: random and corner-case bench for the medium register set.
// assumes pmacs_station as management station and a pull-up on mdio.
`timescale 1ns/10ps
module pmacs_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic link_up = 1'b1;
  logic an_en = 1'b0;
  logic forced = 1'b0;
  logic [6:0] an_type = 7'h00;
  logic [3:0] tx = 4'h0;
  logic [3:0] line = 4'h0;
  logic mdc, st_d, st_oe, d_out, d_oe, srst, pd, lb, mdio_wire;
  logic [6:0] ptype;
  logic [3:0] rx;
  logic [31:0] lfsr = 32'h000185c2;
  logic [15:0] q, d;
  logic [15:0] ofs_t [4] = '{16'h0005, 16'h0006, 16'h0003, 16'h0007};
  logic [15:0] exp_t [4] = '{pmacs_pkg::PKG1_VAL, pmacs_pkg::PKG2_VAL,
                             16'h0000, {9'h000, pmacs_pkg::TYPE_RST}};
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int srst_cyc = 0;
  // nobody driving leaves the pull-up level
  assign mdio_wire = d_oe ? d_out : (st_oe ? st_d : 1'b1);
  always #5 clk = ~clk;
  pmacs_station st (.i_clk(clk), .i_mdio_wire(mdio_wire), .o_mdc(mdc),
    .o_mdio_drive(st_d), .o_mdio_oe(st_oe));
  pmacs_regs dut (.i_clk(clk), .i_rst_n(rst_n), .i_mdc(mdc),
    .i_mdio_in(mdio_wire), .i_power_down_strap_pin(strap),
    .i_link_up(link_up), .i_an_enable(an_en), .i_forced_cfg(forced),
    .i_an_phy_type(an_type), .i_tx_sym(tx), .i_line_sym(line),
    .o_mdio_out(d_out), .o_mdio_oe(d_oe), .o_soft_reset_active(srst),
    .o_power_down(pd), .o_local_loopback(lb), .o_phy_type(ptype),
    .o_rx_sym(rx));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [6:0] exp_type(input logic a, input logic f,
                                          input logic [6:0] t);
    return (!a && f) ? pmacs_pkg::TYPE_RST : t;
  endfunction : exp_type
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (srst === 1'b1) srst_cyc <= srst_cyc + 1;
    if (cyc == 90000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    lfsr = nxt(lfsr);
    strap <= lfsr[0];
    // three edges fill the pin synchronisers, which carry no reset
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({15'h0, pd}, {15'h0, strap});
    st.rd(pmacs_pkg::OFS_CTRL1, q);
    chk(q, {4'h0, strap, 11'h000});
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      st.wr(ofs_t[k], k == 3 ? exp_t[3] : lfsr[15:0]);
      st.rd(ofs_t[k], q);
      chk(q, exp_t[k]);
    end
    // read with post-increment walks offsets 0x5, 0x6 and 0x7
    st.frame(pmacs_pkg::OP_ADDR, pmacs_pkg::OFS_PKG1, q);
    for (int k = 0; k < 3; k++) begin
      st.frame(pmacs_pkg::OP_RDINC, 16'h0000, q);
      chk(q, exp_t[k == 2 ? 3 : k]);
    end
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        link_up <= 1'b0;
        repeat (3) @(posedge clk);
        link_up <= 1'b1;
      end
      st.rd(pmacs_pkg::OFS_STAT1, q);
      chk(q, k[0] ? 16'h0006 : 16'h0002);
    end
    for (int k = 0; k < 5; k++) begin
      lfsr = nxt(lfsr);
      st.half = 5 + lfsr[17:16];
      d = (k == 0) ? 16'h7fff : lfsr[15:0] & 16'h7fff;
      st.wr(pmacs_pkg::OFS_CTRL1, d);
      repeat (4) @(posedge clk);
      tx <= lfsr[23:20];
      line <= lfsr[27:24];
      @(posedge clk);
      #1;
      chk({12'h0, rx}, {12'h0, d[0] ? tx : line});
      chk({14'h0, pd, lb}, {14'h0, d[11], d[0]});
      st.rd(pmacs_pkg::OFS_CTRL1, q);
      chk(q, d & 16'h0801);
    end
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      @(posedge clk);
      an_en <= k[0];
      forced <= k[1];
      an_type <= lfsr[6:0];
      @(posedge clk);
      #1;
      chk({9'h0, ptype}, {9'h0, exp_type(an_en, forced, an_type)});
    end
    @(posedge clk);
    strap <= ~strap;
    @(posedge clk);
    st.wr(pmacs_pkg::OFS_CTRL1, strap ? 16'h8001 : 16'h8801);
    repeat (150) @(posedge clk);
    #1;
    chk(16'(srst_cyc), 16'(pmacs_pkg::SOFT_RST_CYC));
    chk({14'h0, pd, lb}, {14'h0, strap, 1'b0});
    st.rd(pmacs_pkg::OFS_CTRL1, q);
    chk(q, {4'h0, strap, 11'h000});
    tally_and_finish();
  end
endmodule : pmacs_regs_tb
